// File: bench/dsom_coil_model.sv
/* Relay coils on the open-collector terminals.
 Assumes one coil per terminal. */
`timescale 1ns/1ns
`default_nettype none
module dsom_coil_model (
    input wire logic [5:0] term_out_en,
    input wire logic [5:0] term_out,
    output logic [5:0] coil_on
);
    // A released terminal is pulled up through the coil, so it reads high
    assign coil_on = ~((term_out_en & term_out) | ~term_out_en);
endmodule : dsom_coil_model
`default_nettype wire

// File: bench/dsom_props.sv
/* Checker on the output mapper ports.
 Assumes bind from tb, one clock. */
`timescale 1ns/1ns
`default_nettype none
module dsom_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic drive_running,
    input wire logic alarm_active,
    input wire logic [15:0] out_freq,
    input wire logic [15:0] set_frequency_param,
    input wire logic [15:0] start_frequency_param,
    input wire logic [15:0] accel_threshold_one,
    input wire logic [15:0] decel_threshold_one,
    input wire logic [15:0] hyst_band,
    input wire logic [35:0] func_sel,
    input wire logic func_sel_load,
    input wire logic [5:0] term_out_en,
    input wire logic [5:0] term_out,
    input wire logic [5:0] status_level
);
    logic [35:0] sel_ff;
    logic [15:0] prev_ff;
    logic [1:0] up_ff;
    logic [1:0] ld_ff;
    // Judged only from three edges past reset, with no selector load on the last two edges
    wire logic ok = up_ff == 2'h3 && ld_ff == 2'h0;
    wire logic acc = out_freq > prev_ff;
    wire logic drop = out_freq < prev_ff && {1'b0, out_freq} + {1'b0, hyst_band} <
        {1'b0, decel_threshold_one};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_ff <= {6'h05, 30'h0};
            prev_ff <= 16'h0;
            up_ff <= 2'h0;
            ld_ff <= 2'h0;
        end else begin
            if (func_sel_load) sel_ff <= func_sel;
            prev_ff <= out_freq;
            up_ff <= up_ff + {1'b0, up_ff != 2'h3};
            ld_ff <= {ld_ff[0], func_sel_load};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_run;
        ok && sel_ff[5:0] == 6'h00 |->
            status_level[0] == $past(drive_running && out_freq > start_frequency_param);
    endproperty
    a_run: assert property (p_run) else $error("run level wrong");
    property p_alarm;
        ok && sel_ff[35:30] == 6'h05 |-> status_level[5] == $past(alarm_active);
    endproperty
    a_alarm: assert property (p_alarm) else $error("relay alarm wrong");
    property p_open;
        term_out == 6'h00 && status_level == term_out_en;
    endproperty
    a_open: assert property (p_open) else $error("terminal drive wrong");
    property p_refuse;
        ok && !(sel_ff[29:24] inside {6'h00, 6'h01, 6'h02, 6'h05, 6'h06}) |-> !status_level[4];
    endproperty
    a_refuse: assert property (p_refuse) else $error("unknown code drives");
    property p_set_on;
        ok && sel_ff[11:6] == 6'h01 && $past(drive_running) &&
            $past(drive_running && out_freq == set_frequency_param, 2) |-> status_level[1];
    endproperty
    a_set_on: assert property (p_set_on) else $error("at set missed");
    property p_set_off;
        ok && sel_ff[11:6] == 6'h01 && $past(!drive_running, 2) |-> !status_level[1];
    endproperty
    a_set_off: assert property (p_set_off) else $error("at set while stopped");
    property p_over_on;
        ok && sel_ff[17:12] == 6'h02 && $past(acc && out_freq >= accel_threshold_one, 2)
            |-> status_level[2];
    endproperty
    a_over_on: assert property (p_over_on) else $error("over missed");
    property p_over_off;
        ok && sel_ff[17:12] == 6'h02 && $past(drop, 2) |-> !status_level[2];
    endproperty
    a_over_off: assert property (p_over_off) else $error("over held");
    property p_at_t1;
        ok && sel_ff[23:18] == 6'h06 && $past(drive_running) &&
            $past(drive_running && acc && out_freq == accel_threshold_one, 2) |-> status_level[3];
    endproperty
    a_at_t1: assert property (p_at_t1) else $error("at threshold missed");
    c_run: cover property (ok && status_level[0]);
    c_over: cover property (status_level[2] ##1 !status_level[2]);
    c_at: cover property (status_level[3]);
endmodule : dsom_props
`default_nettype wire

// File: bench/tb.sv
/* Bench: random run and alarm, then a directed frequency profile.
 Assumes checker and coil model compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 0, rst_n = 0, run = 0, alm = 0, load = 0;
    logic [15:0] f = 16'h0;
    logic [35:0] sel = 36'h0;
    logic [5:0] en, lvl, st, coil;
    int err_total = 0, checks_done = 0, i;
    integer seed = 32'h0d5c;
    dsom_output_mapper DUT (.clk(clk), .rst_n(rst_n), .drive_running(run), .alarm_active(alm),
        .out_freq(f), .set_frequency_param(16'h0064), .start_frequency_param(16'h0005),
        .accel_threshold_one(16'h0050), .decel_threshold_one(16'h0030),
        .hyst_band(16'h0004), .func_sel(sel), .func_sel_load(load), .term_out_en(en),
        .term_out(lvl), .status_level(st));
    dsom_coil_model u_coil (.term_out_en(en), .term_out(lvl), .coil_on(coil));
    function automatic logic exp_run(input logic r, input logic [15:0] v);
        return r && v > 16'h0005;
    endfunction : exp_run
    task automatic chk(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask : chk
    task automatic hold(input logic [15:0] v);
        f = v;
        repeat (3) @(negedge clk);
    endtask : hold
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        forever #4 clk = ~clk;
    end
    initial begin
        #20000;
        err_total++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst_n = 1;
        for (i = 0; i < 300; i++) begin
            @(negedge clk);
            if (i > 0) chk("run_coil", exp_run(run, f), coil[0]);
            if (i > 0) chk("relay_alarm", alm, coil[5]);
            run = 1'($random(seed));
            alm = 1'($random(seed));
            f = 16'($random(seed)) & 16'h000f;
        end
        $display("test random_run done");
        sel = {6'h00, 6'h07, 6'h06, 6'h02, 6'h01, 6'h00};
        load = 1;
        run = 1;
        f = 16'h0;
        @(negedge clk);
        load = 0;
        for (i = 0; i <= 16'h0064; i += 4) begin
            @(negedge clk);
            if (i == 16'h0058) chk("at_thr", 1'b1, st[3]);
            f = i[15:0];
        end
        hold(16'h0064);
        chk("at_set", 1'b1, st[1]);
        chk("over_on", 1'b1, st[2]);
        chk("unknown_code", 1'b0, st[4]);
        chk("relay_run", 1'b1, coil[5]);
        hold(16'h0067);
        chk("set_band", 1'b1, st[1]);
        hold(16'h006a);
        chk("set_left", 1'b0, st[1]);
        for (i = 16'h0064; i >= 0; i -= 4) begin
            @(negedge clk);
            if (i == 16'h0028) chk("at_thr_dec", 1'b1, st[3]);
            f = i[15:0];
        end
        hold(16'h0);
        chk("over_off", 1'b0, st[2]);
        run = 0;
        repeat (3) @(negedge clk);
        chk("stop", 1'b0, coil[0]);
        $display("test profile done");
        print_verdict();
    end
endmodule : tb
bind dsom_output_mapper dsom_props u_props (.clk(clk), .rst_n(rst_n),
    .drive_running(drive_running), .alarm_active(alarm_active), .out_freq(out_freq),
    .set_frequency_param(set_frequency_param), .start_frequency_param(start_frequency_param),
    .accel_threshold_one(accel_threshold_one), .decel_threshold_one(decel_threshold_one),
    .hyst_band(hyst_band), .func_sel(func_sel), .func_sel_load(func_sel_load),
    .term_out_en(term_out_en), .term_out(term_out), .status_level(status_level));
`default_nettype wire

// File: rtl/dsom_consts.svh
/*
 Constants for the drive status output mapper: function codes, reset values,
 widths. Assumes inclusion by bare name from rtl files.
*/
`ifndef DSOM_CONSTS_SVH
`define DSOM_CONSTS_SVH
`define DSOM_FUNC_W 6
`define DSOM_FREQ_W 16
`define DSOM_NUM_OUT 6
`define DSOM_RELAY_IDX 5
`define DSOM_FN_RUN 6'h00
`define DSOM_FN_AT_SET 6'h01
`define DSOM_FN_OVER_T1 6'h02
`define DSOM_FN_AT_T1 6'h06
`define DSOM_FN_ALARM 6'h05
`define DSOM_HYST_DEF 16'h000a
`endif

// File: rtl/dsom_freq_arrival.sv
/*
 Frequency-arrival comparator with hysteresis; produces run, at-set-speed,
 over-threshold and at-threshold levels. Inputs are synchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "dsom_consts.svh"
module dsom_freq_arrival #(
    parameter int FREQ_W = `DSOM_FREQ_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic drive_running,
    input wire logic alarm_active,
    input wire logic [FREQ_W-1:0] out_freq,
    input wire logic [FREQ_W-1:0] set_frequency_param,
    input wire logic [FREQ_W-1:0] start_frequency_param,
    input wire logic [FREQ_W-1:0] accel_threshold_one,
    input wire logic [FREQ_W-1:0] decel_threshold_one,
    input wire logic [FREQ_W-1:0] hyst_band,
    dsom_status_if.src st_if
);
    // Refuse widths that the one-bit-wider difference arithmetic cannot carry
    if (FREQ_W < 2 || FREQ_W > 31) begin : g_bad_freq_w
        $error("FREQ_W out of range");
    end

    // Within band: |a-b| <= h, computed in a wider width to avoid wrap
    function automatic logic near(input logic [FREQ_W-1:0] a, input logic [FREQ_W-1:0] b,
                                  input logic [FREQ_W-1:0] h);
        logic [FREQ_W:0] d;
        d = (a >= b) ? ({1'b0, a} - {1'b0, b}) : ({1'b0, b} - {1'b0, a});
        return d <= {1'b0, h};
    endfunction : near

    logic [FREQ_W-1:0] prev_freq_ff;
    logic accel_ff, decel_ff;
    logic at_set_speed_flag_ff, over_threshold_one_flag_ff, at_threshold_one_flag_ff;
    logic nxt_at_set, nxt_over, nxt_at_t1, nxt_accel, nxt_decel;
    logic [FREQ_W:0] set_hi;
    logic [FREQ_W:0] dec_lo;

    always_comb begin
        nxt_accel = accel_ff;
        nxt_decel = decel_ff;
        if (out_freq > prev_freq_ff) begin
            nxt_accel = 1'b1;
            nxt_decel = 1'b0;
        end else if (out_freq < prev_freq_ff) begin
            nxt_accel = 1'b0;
            nxt_decel = 1'b1;
        end
        set_hi = {1'b0, set_frequency_param} + {1'b0, hyst_band};
        dec_lo = ({1'b0, decel_threshold_one} > {1'b0, hyst_band}) ?
                 {1'b0, decel_threshold_one} - {1'b0, hyst_band} : '0;
        // Wider band to drop than to catch, so a hovering frequency cannot chatter
        nxt_at_set = at_set_speed_flag_ff ? near(out_freq, set_frequency_param, hyst_band)
                   : (out_freq == set_frequency_param);
        nxt_over = over_threshold_one_flag_ff;
        if (!over_threshold_one_flag_ff && nxt_accel && out_freq >= accel_threshold_one)
            nxt_over = 1'b1;
        else if (over_threshold_one_flag_ff && nxt_decel && {1'b0, out_freq} < dec_lo)
            nxt_over = 1'b0;
        nxt_at_t1 = at_threshold_one_flag_ff ?
            ((nxt_accel && near(out_freq, accel_threshold_one, hyst_band)) ||
             (nxt_decel && near(out_freq, decel_threshold_one, hyst_band))) :
            ((nxt_accel && out_freq == accel_threshold_one) ||
             (nxt_decel && out_freq == decel_threshold_one));
        if (!drive_running) begin
            nxt_at_set = 1'b0;
            nxt_at_t1 = 1'b0;
        end
        if (set_hi == '0) nxt_at_set = 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_freq_ff <= '0;
            accel_ff <= 1'b0;
            decel_ff <= 1'b0;
            at_set_speed_flag_ff <= 1'b0;
            over_threshold_one_flag_ff <= 1'b0;
            at_threshold_one_flag_ff <= 1'b0;
        end else begin
            prev_freq_ff <= out_freq;
            accel_ff <= nxt_accel;
            decel_ff <= nxt_decel;
            at_set_speed_flag_ff <= nxt_at_set;
            over_threshold_one_flag_ff <= nxt_over;
            at_threshold_one_flag_ff <= nxt_at_t1;
        end
    end

    always_comb begin
        st_if.st.run = drive_running && (out_freq > start_frequency_param);
        st_if.st.at_set = at_set_speed_flag_ff;
        st_if.st.over_t1 = over_threshold_one_flag_ff;
        st_if.st.at_t1 = at_threshold_one_flag_ff;
        st_if.st.alarm = alarm_active;
    end
endmodule : dsom_freq_arrival
`default_nettype wire

// File: rtl/dsom_output_mapper.sv
/*
 Drive status output mapper: five open-collector logic outputs plus one relay
 output, each with its own function selector. Inputs synchronous to clk.
*/
// Function
// - Five logic outputs each have an independent function selector routing any function.
// - The relay output carries the alarm function after reset and may be given any other.
// - Code 00 asserts the output while the drive runs above the start frequency and drops it while stopped.
// - Run indication is active low, pulling to common when asserted, open otherwise.
// - Run indication asserts while output frequency is above the start frequency.
// - Code 01 asserts while output frequency equals the set frequency; the code also needs the drive running and a nonzero set frequency or band.
// - Code 02 asserts once frequency reaches the first accel threshold while accelerating.
// - Turn-on and turn-off thresholds are separate for accel and decel.
// - Every arrival transition has hysteresis against chatter near a threshold.
// - The over-threshold output drops when frequency falls below the decel threshold less the hysteresis band.
// - Code 06 asserts only at the accel threshold in accel or the decel threshold in decel.
`timescale 1ns/1ns
`default_nettype none
`include "dsom_consts.svh"
module dsom_output_mapper #(
    parameter int NUM_OUT = `DSOM_NUM_OUT,
    parameter int FREQ_W = `DSOM_FREQ_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic drive_running,
    input wire logic alarm_active,
    input wire logic [FREQ_W-1:0] out_freq,
    input wire logic [FREQ_W-1:0] set_frequency_param,
    input wire logic [FREQ_W-1:0] start_frequency_param,
    input wire logic [FREQ_W-1:0] accel_threshold_one,
    input wire logic [FREQ_W-1:0] decel_threshold_one,
    input wire logic [FREQ_W-1:0] hyst_band,
    input wire logic [NUM_OUT*`DSOM_FUNC_W-1:0] func_sel,
    input wire logic func_sel_load,
    output logic [NUM_OUT-1:0] term_out_en,
    output logic [NUM_OUT-1:0] term_out,
    output logic [NUM_OUT-1:0] status_level
);
    // The relay index and selector packing assume five logic outputs plus the relay
    if (NUM_OUT != `DSOM_NUM_OUT) begin : g_bad_num_out
        $error("NUM_OUT must be five logic outputs plus relay");
    end

    dsom_status_if st_if ();

    dsom_freq_arrival #(.FREQ_W(FREQ_W)) u_fa (
        .clk(clk),
        .rst_n(rst_n),
        .drive_running(drive_running),
        .alarm_active(alarm_active),
        .out_freq(out_freq),
        .set_frequency_param(set_frequency_param),
        .start_frequency_param(start_frequency_param),
        .accel_threshold_one(accel_threshold_one),
        .decel_threshold_one(decel_threshold_one),
        .hyst_band(hyst_band),
        .st_if(st_if.src)
    );

    function automatic logic pick(input dsom_pkg::dsom_func_t f, input dsom_pkg::dsom_status_s s);
        case (f)
            `DSOM_FN_RUN: return s.run;
            `DSOM_FN_AT_SET: return s.at_set;
            `DSOM_FN_OVER_T1: return s.over_t1;
            `DSOM_FN_AT_T1: return s.at_t1;
            `DSOM_FN_ALARM: return s.alarm;
            default: return 1'b0;
        endcase
    endfunction : pick

    dsom_pkg::dsom_func_t sel_ff [NUM_OUT];
    dsom_pkg::dsom_func_t nxt_sel [NUM_OUT];
    logic [NUM_OUT-1:0] level_ff, nxt_level;

    always_comb begin
        for (int i = 0; i < NUM_OUT; i++) begin
            nxt_sel[i] = sel_ff[i];
            if (func_sel_load)
                nxt_sel[i] = func_sel[i*`DSOM_FUNC_W +: `DSOM_FUNC_W];
            nxt_level[i] = pick(sel_ff[i], st_if.st);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_OUT; i++) begin
                // Relay defaults to alarm, transistors to run
                sel_ff[i] <= (i == `DSOM_RELAY_IDX) ? `DSOM_FN_ALARM : `DSOM_FN_RUN;
            end
            level_ff <= '0;
        end else begin
            for (int i = 0; i < NUM_OUT; i++) begin
                sel_ff[i] <= nxt_sel[i];
            end
            level_ff <= nxt_level;
        end
    end

    // Open collector: pin driven low only when asserted, released otherwise
    assign term_out_en = level_ff;
    assign term_out = '0;
    assign status_level = level_ff;
endmodule : dsom_output_mapper
`default_nettype wire

// File: rtl/dsom_pkg.sv
/*
 Types for the drive status output mapper.
 Assumes the consts header is compiled alongside.
*/
`include "dsom_consts.svh"
package dsom_pkg;
    typedef logic [`DSOM_FUNC_W-1:0] dsom_func_t;
    typedef logic [`DSOM_FREQ_W-1:0] dsom_freq_t;
    typedef struct packed {
        logic run;
        logic at_set;
        logic over_t1;
        logic at_t1;
        logic alarm;
    } dsom_status_s;
endpackage : dsom_pkg

// File: rtl/dsom_status_if.sv
/*
 Interface carrying the computed status levels from the comparator to the mapper.
 Assumes one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
interface dsom_status_if;
    dsom_pkg::dsom_status_s st;
    modport src (output st);
    modport dst (input st);
endinterface : dsom_status_if
`default_nettype wire
